/* src/aros_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "aros_defs.vh"

module aros_top #(
   parameter integer CONV_CYCLES = `AROS_CONV_CYCLES,
   parameter WORD_BITS = `AROS_WORD_BITS,
   parameter FIFO_DEPTH = `AROS_FIFO_DEPTH
) (
   input wire CLK_SYS,
   input wire RESETN,
   input wire CS_N,
   input wire SCLK_I,
   output wire SCLK_O,
   output wire SCLK_OE,
   input wire MODE_MASTER,
   input wire CRYSTAL_INPUT,
   input wire [WORD_BITS-1:0] RESULT_DATA,
   input wire RESULT_VALID,
   output wire RESULT_READY,
   output wire DOUT_O,
   output wire DOUT_OE,
   output wire CONV_TICK
);

   localparam ST_IDLE = 2'h0;
   localparam ST_READY = 2'h1;
   localparam ST_SHIFT = 2'h2;
   localparam integer CONV_LAST_I = CONV_CYCLES - 1;
   localparam integer LAST_BIT_I = WORD_BITS;
   localparam [`AROS_CONV_CNT_W-1:0] CONV_LAST = CONV_LAST_I[`AROS_CONV_CNT_W-1:0];
   localparam [`AROS_BIT_CNT_W-1:0] LAST_BIT = LAST_BIT_I[`AROS_BIT_CNT_W-1:0];

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   reg [`AROS_SYN_W-1:0] sync1_reg;
   reg [`AROS_SYN_W-1:0] sync2_reg;
   reg [`AROS_SYN_W-1:0] prev_reg;
   wire [`AROS_SYN_W-1:0] pins;

   assign pins = {MODE_MASTER, CS_N, SCLK_I, CRYSTAL_INPUT};

   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         sync1_reg <= `AROS_SYN_IDLE;
         sync2_reg <= `AROS_SYN_IDLE;
         prev_reg <= `AROS_SYN_IDLE;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   wire xtal_edge = sync2_reg[`AROS_SYN_XTAL] ^ prev_reg[`AROS_SYN_XTAL];
   wire sclk_in_fall = prev_reg[`AROS_SYN_SCLK] && !sync2_reg[`AROS_SYN_SCLK];
   wire sclk_in_rise = !prev_reg[`AROS_SYN_SCLK] && sync2_reg[`AROS_SYN_SCLK];
   wire cs_low = !sync2_reg[`AROS_SYN_CSN];

   // ----------------------------------------
   // Mode strap capture
   // ----------------------------------------
   // The strap is read once, after the synchroniser has filled, so a pin that moves later is ignored
   reg [1:0] strap_wait_reg;
   reg master_reg;

   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         strap_wait_reg <= 2'h0;
         master_reg <= 1'b0;
      end else if (strap_wait_reg != 2'h3) begin
         strap_wait_reg <= strap_wait_reg + 2'h1;
         if (strap_wait_reg == 2'h2) begin
            master_reg <= sync2_reg[`AROS_SYN_MODE];
         end
      end
   end

   wire strap_done = (strap_wait_reg == 2'h3);

   // ----------------------------------------
   // Conversion rate timer
   // ----------------------------------------
   reg [`AROS_CONV_CNT_W-1:0] conv_cnt_reg;
   reg tick_reg;

   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         conv_cnt_reg <= {`AROS_CONV_CNT_W{1'b0}};
         tick_reg <= 1'b0;
      end else if (conv_cnt_reg == CONV_LAST) begin
         conv_cnt_reg <= {`AROS_CONV_CNT_W{1'b0}};
         tick_reg <= 1'b1;
      end else begin
         conv_cnt_reg <= conv_cnt_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Result buffer
   // ----------------------------------------
   // Drained only at the update rate, so a fast source fills it and is stalled by RESULT_READY
   wire [WORD_BITS-1:0] fifo_data;
   wire fifo_valid;
   wire fifo_pop;
   wire fifo_ready;

   aros_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(FIFO_DEPTH),
      .AW(`AROS_FIFO_AW)
   ) u_fifo (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .in_data(RESULT_DATA),
      .in_valid(RESULT_VALID),
      .in_ready(fifo_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   assign RESULT_READY = fifo_ready;

   // ----------------------------------------
   // Serial output engine
   // ----------------------------------------
   reg [1:0] state_reg;
   reg [WORD_BITS-1:0] shift_reg;
   reg [`AROS_BIT_CNT_W-1:0] bit_cnt_reg;
   reg [1:0] lead_cnt_reg;
   reg dout_reg;
   reg dout_oe_reg;
   reg sclk_reg;
   reg sclk_oe_reg;

   wire loadable = (state_reg != ST_SHIFT) && strap_done;
   // A word waiting in the buffer is taken only while no frame is being shifted
   assign fifo_pop = tick_reg && fifo_valid && loadable;

   wire lead_done = (lead_cnt_reg == `AROS_LEAD_EDGES);
   wire m_run = master_reg && cs_low;
   wire m_fall = m_run && xtal_edge && sclk_reg &&
                 ((state_reg == ST_SHIFT) || ((state_reg == ST_READY) && lead_done));
   wire m_rise = m_run && xtal_edge && !sclk_reg && (state_reg == ST_SHIFT);
   wire fall_ev = master_reg ? m_fall : (cs_low && sclk_in_fall);
   wire rise_ev = master_reg ? m_rise : (cs_low && sclk_in_rise);

   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ST_IDLE;
         shift_reg <= {WORD_BITS{1'b0}};
         bit_cnt_reg <= {`AROS_BIT_CNT_W{1'b0}};
         lead_cnt_reg <= 2'h0;
         dout_reg <= 1'b1;
         dout_oe_reg <= 1'b0;
         sclk_reg <= 1'b1;
         sclk_oe_reg <= 1'b0;
      end else begin
         dout_oe_reg <= cs_low;
         sclk_oe_reg <= master_reg && strap_done;
         if (!cs_low) begin
            // A frame cut short by chip select is dropped; the word is not offered again
            if (state_reg == ST_SHIFT) begin
               state_reg <= ST_IDLE;
            end
            dout_reg <= 1'b1;
            sclk_reg <= 1'b1;
            lead_cnt_reg <= 2'h0;
            if (fifo_pop) begin
               shift_reg <= fifo_data;
               state_reg <= ST_READY;
            end
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  dout_reg <= 1'b1;
                  lead_cnt_reg <= 2'h0;
                  if (fifo_pop) begin
                     shift_reg <= fifo_data;
                     state_reg <= ST_READY;
                  end
               end
               ST_READY: begin
                  dout_reg <= 1'b0;
                  if (fifo_pop) begin
                     shift_reg <= fifo_data;
                  end else if (fall_ev) begin
                     dout_reg <= shift_reg[WORD_BITS-1];
                     shift_reg <= {shift_reg[WORD_BITS-2:0], 1'b0};
                     bit_cnt_reg <= {{(`AROS_BIT_CNT_W-1){1'b0}}, 1'b1};
                     state_reg <= ST_SHIFT;
                     if (master_reg) begin
                        sclk_reg <= 1'b0;
                     end
                  end
                  if (master_reg && xtal_edge && !lead_done) begin
                     lead_cnt_reg <= lead_cnt_reg + 2'h1;
                  end
               end
               ST_SHIFT: begin
                  if (fall_ev) begin
                     if (bit_cnt_reg != LAST_BIT) begin
                        dout_reg <= shift_reg[WORD_BITS-1];
                        shift_reg <= {shift_reg[WORD_BITS-2:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                     end
                     if (master_reg) begin
                        sclk_reg <= 1'b0;
                     end
                  end else if (rise_ev) begin
                     if (master_reg) begin
                        sclk_reg <= 1'b1;
                     end
                     if (bit_cnt_reg == LAST_BIT) begin
                        dout_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                        lead_cnt_reg <= 2'h0;
                     end
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
                  dout_reg <= 1'b1;
               end
            endcase
         end
      end
   end

   // Master clock stops high between frames so the host sees no stray falling edge
   assign DOUT_O = dout_reg;
   assign DOUT_OE = dout_oe_reg;
   assign SCLK_O = sclk_reg;
   assign SCLK_OE = sclk_oe_reg;
   assign CONV_TICK = tick_reg;

endmodule

`default_nettype wire

/* src/aros_defs.vh */
// What this block does
// - With the 32.768 kHz crystal a new conversion result is produced every 50.54 ms, a 19.79 Hz update rate.
// - Driving chip select low takes the data output out of high impedance so it is actively driven.
// - The data output changes on the falling edge of the serial clock, in both modes.
// - Chip select returning high releases the data output to high impedance.
// - Once the serial clock returns to its idle level after the last data bit, the data output is driven high.
// - In master mode the serial clock is made from the crystal, each high and low phase half a crystal period.
// - In master mode the first falling serial clock edge comes 0.5 to 1 crystal period after data falls low.
`ifndef AROS_DEFS_VH
`define AROS_DEFS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define AROS_CLK_MHZ 50
`define AROS_T_ADC_MS 50.54
// Whole clock count of one conversion period at the system clock, kept integer so no real value reaches a counter
`define AROS_CONV_CYCLES 2527000
`define AROS_CONV_CNT_W 22
`define AROS_LEAD_EDGES 2'h1

// ----------------------------------------
// Data word
// ----------------------------------------
`define AROS_WORD_BITS 24
`define AROS_BIT_CNT_W 5
`define AROS_FIFO_DEPTH 4
`define AROS_FIFO_AW 2

// ----------------------------------------
// Synchroniser lanes
// ----------------------------------------
`define AROS_SYN_W 4
`define AROS_SYN_XTAL 0
`define AROS_SYN_SCLK 1
`define AROS_SYN_CSN 2
`define AROS_SYN_MODE 3
`define AROS_SYN_IDLE 4'hf

`endif

/* src/aros_fifo.v */
`timescale 1ns/1ps
`default_nettype none

module aros_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output reg in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   reg [AW:0] count_next;
   wire push;
   wire pop;

   // ----------------------------------------
   // Flow control
   // ----------------------------------------
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_reg];

   always @* begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   function [AW-1:0] wrap_inc;
      input [AW-1:0] p;
      begin
         if (p == DEPTH - 1) begin
            wrap_inc = {AW{1'b0}};
         end else begin
            wrap_inc = p + 1'b1;
         end
      end
   endfunction

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Ready is registered so the source sees a clean flop, one word of slack is never needed
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wrap_inc(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= wrap_inc(rd_ptr_reg);
         end
         count_reg <= count_next;
         in_ready <= (count_next != DEPTH);
      end
   end

endmodule

`default_nettype wire

/* tb/aros_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module aros_asserts #(
   parameter integer CONV_CYCLES = 1000
) (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CS_N,
   input wire logic SCLK_I,
   input wire logic SCLK_O,
   input wire logic SCLK_OE,
   input wire logic DOUT_O,
   input wire logic DOUT_OE,
   input wire logic CONV_TICK
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   integer tcnt, hcnt;
   logic seen;
   logic [3:0] tsh;
   // Recent ticks excuse the ready fall of the data line
   always @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         tcnt <= 0;
         hcnt <= 0;
         seen <= 1'b0;
         tsh <= 4'h0;
      end else begin
         tcnt <= CONV_TICK ? 0 : tcnt + 1;
         hcnt <= (SCLK_OE && SCLK_O && !CS_N) ? hcnt + 1 : 0;
         seen <= seen | CONV_TICK;
         tsh <= {tsh[2:0], CONV_TICK};
      end
   end
   // ----
   // Master frame steps
   // ----
   sequence s_lead;
      SCLK_O [*4];
   endsequence
   sequence s_low;
      !SCLK_O [*2];
   endsequence
   a_tick_pulse: assert property (CONV_TICK |=> !CONV_TICK) else $error("tick too wide");
   a_tick_period: assert property (CONV_TICK && seen |-> tcnt == CONV_CYCLES - 1) else $error("tick period");
   a_oe_drive: assert property ((!CS_N) [*5] |-> DOUT_OE) else $error("dout not driven");
   a_oe_release: assert property (CS_N [*5] |-> !DOUT_OE) else $error("dout not released");
   a_data_fall: assert property (SCLK_I [*6] ##0 (!SCLK_OE && tsh == 4'h0) |-> !$fell(DOUT_O))
      else $error("dout moved while clock high");
   a_idle_high: assert property (hcnt == 20 |-> DOUT_O) else $error("dout not high when idle");
   a_sclk_phase: assert property ($fell(SCLK_O) && SCLK_OE |=> s_low ##[1:2] SCLK_O) else $error("sclk phase");
   a_sclk_idle: assert property (CS_N [*6] |-> SCLK_O) else $error("sclk not idle");
   a_first_edge: assert property ($fell(DOUT_O) && SCLK_O && SCLK_OE |-> s_lead ##[1:10] $fell(SCLK_O))
      else $error("first sclk edge");
endmodule
bind aros_top aros_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_asserts (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .CS_N(CS_N),
   .SCLK_I(SCLK_I), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE), .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE), .CONV_TICK(CONV_TICK));
`default_nettype wire

/* tb/aros_host.sv */
`timescale 1ns/1ps
`default_nettype none
module aros_host (
   input wire logic clk,
   input wire logic dline,
   input wire logic doe,
   input wire logic sline,
   input wire logic soe,
   input wire logic cs_n,
   input wire logic [4:0] ph,
   output logic sclk,
   output logic [23:0] word,
   output logic [7:0] nw
);
   logic pe = 1'b1, lastb = 1'b1, dprev = 1'b1;
   logic [4:0] nb = 5'h0;
   integer k;
   initial begin
      sclk = 1'b1;
      word = 24'h0;
      nw = 8'h0;
   end
   // Slave mode only: a falling data line under chip select starts a read
   // Sampled on the clock, so a glitch of the released line as the output turns on cannot start one
   always @(posedge clk) if (!soe && doe && !cs_n && dprev && !dline) begin
      for (k = 0; k < 24 && !cs_n; k++) begin
         repeat (ph) @(posedge clk);
         #1 sclk = 1'b0;
         repeat (ph) @(posedge clk);
         #1 sclk = 1'b1;
      end
   end
   // Bit is the value seen late in the low phase, so a rise that ends the word cannot race it
   always @(posedge clk) begin
      if (!sline) lastb <= dline;
      if (cs_n) nb <= 5'h0;
      else if (sline && !pe) begin
         word <= {word[22:0], lastb};
         nb <= (nb == 5'h17) ? 5'h0 : nb + 5'h1;
         if (nb == 5'h17) nw <= nw + 8'h1;
      end
      pe <= sline;
      dprev <= dline;
   end
endmodule
`default_nettype wire

/* tb/tb_aros_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_aros_top;
   localparam integer CC = 1000;
   logic clk = 1'b0, rstn = 1'b0, cs_n = 1'b0, mode = 1'b0, xtal = 1'b0, vld = 1'b0, dq = 1'b0;
   logic [23:0] dat = 24'h0;
   logic [23:0] q[$];
   logic [4:0] ph = 5'h5;
   logic [7:0] nw0;
   integer err_count = 0, num_checks = 0, seed = 32'hddf9, n;
   wire logic so, soe, dout, doe, rdy, tick, sclk_h;
   wire logic [23:0] word;
   wire logic [7:0] nw;
   // Released data line shows a changing pattern, never a stale bit
   wire logic dline = doe ? dout : ~dq;
   wire logic sline = soe ? so : sclk_h;
   always #10 clk = ~clk;
   always #80 xtal = ~xtal;
   always @(posedge clk) dq <= dline;
   aros_top #(.CONV_CYCLES(CC)) dut (.CLK_SYS(clk), .RESETN(rstn), .CS_N(cs_n), .SCLK_I(sline), .SCLK_O(so),
      .SCLK_OE(soe), .MODE_MASTER(mode), .CRYSTAL_INPUT(xtal), .RESULT_DATA(dat), .RESULT_VALID(vld),
      .RESULT_READY(rdy), .DOUT_O(dout), .DOUT_OE(doe), .CONV_TICK(tick));
   aros_host host (.clk(clk), .dline(dline), .doe(doe), .sline(sline), .soe(soe), .cs_n(cs_n), .ph(ph),
      .sclk(sclk_h), .word(word), .nw(nw));
   task chk(input logic [23:0] g, input logic [23:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Valid is left high so back-to-back words need no idle cycle
   task push(input logic [23:0] d);
      vld = 1'b1;
      dat = d;
      while (rdy !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
      q.push_back(d);
   endtask
   task frame;
      n = 0;
      nw0 = nw;
      while (nw === nw0 && n < 3 * CC) begin
         @(posedge clk) #1;
         n++;
      end
      if (n >= 3 * CC) err_count++;
      chk(word, q.pop_front());
      repeat (8) @(posedge clk);
      #1 chk({23'h0, dline}, 24'h1);
      ph = 5'h5 + {2'h0, 3'($random(seed))};
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      push(24'hc00001);
      push(24'h7ffffe);
      push(24'hffffff);
      push(24'h000001);
      vld = 1'b0;
      @(posedge clk) #1 chk({23'h0, rdy}, 24'h0);
      chk({23'h0, soe}, 24'h0);
      push(24'($random(seed)));
      vld = 1'b0;
      repeat (5) frame;
      push(24'($random(seed)));
      vld = 1'b0;
      while (dline !== 1'b0) @(posedge clk) #1;
      repeat (40) @(posedge clk);
      #1 cs_n = 1'b1;
      repeat (6) @(posedge clk);
      #1 chk({23'h0, doe}, 24'h0);
      void'(q.pop_front());
      repeat (30) @(posedge clk);
      #1 cs_n = 1'b0;
      repeat (6) @(posedge clk);
      #1 chk({23'h0, doe}, 24'h1);
      push(24'($random(seed)));
      vld = 1'b0;
      frame;
      rstn = 1'b0;
      mode = 1'b1;
      q.delete();
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (6) @(posedge clk);
      #1 chk({23'h0, soe}, 24'h1);
      push(24'h555555);
      push(24'($random(seed)));
      push(24'h000000);
      vld = 1'b0;
      repeat (3) frame;
      push(24'($random(seed)));
      vld = 1'b0;
      while (dline !== 1'b0) @(posedge clk) #1;
      repeat (40) @(posedge clk) #1;
      // Cut the master frame while its clock is high, so no short low phase is made
      while (so !== 1'b0) @(posedge clk) #1;
      while (so !== 1'b1) @(posedge clk) #1;
      cs_n = 1'b1;
      repeat (8) @(posedge clk);
      #1 chk({23'h0, so}, 24'h1);
      chk({23'h0, doe}, 24'h0);
      stop_test;
   end
   initial begin
      #(CC * 800);
      err_count++;
      stop_test;
   end
endmodule
`default_nettype wire
